/* File: bhcr_defines.svh */
// Contract
// - The expansion ROM base register reads as all zeros and writes to it are dropped.
// - The interrupt line byte is an 8-bit read/write store, reset to zero, that steers nothing.
// - The interrupt pin byte decodes 0 as no interrupt and 1 to 4 as INTA to INTD; reset is 0.
// - Bridge control bit 0 clear ignores poisoned secondary TLPs; set detects and reports them.
// - Bridge control bit 1 set forwards secondary error messages to the primary side.
// - Forwarded errors are reported upstream only with command or device-control reporting on.
// - Bridge control bit 2 clear forwards every in-range I/O address downstream.
// - Bit 2 set sends in-range I/O below 64 KB in the top 768 bytes of each 1 KB upstream.
// - Bridge control bit 3 set forwards VGA addresses downstream; clear blocks them.
// - Bridge control bit 4 affects VGA I/O decoding only while bit 3 is set.
// - Bit 4 at 0 decodes 10 I/O address bits, so aliases match; at 1 it decodes 16 bits (the code compares all 32 bits).
// - Writing 1 to bridge control bit 6 triggers a secondary bus reset.
`ifndef BHCR_DEFINES_SVH
`define BHCR_DEFINES_SVH
// Register indices; each register owns one word at four times its index
`define BHCR_IDX_ROM 8'h38
`define BHCR_IDX_LINE 8'h3C
`define BHCR_IDX_PIN 8'h3D
`define BHCR_IDX_BRIDGE_CONTROL 8'h3E
// Event words take the free indices after the ROM word so the 8-bit bus still reaches them
`define BHCR_IDX_EVT_STAT 8'h39
`define BHCR_IDX_EVT_MASK 8'h3A
`define BHCR_IDX_ERR_CFG 8'h3B
`define BHCR_ADDR_ROM (8'(`BHCR_IDX_ROM << 2))
`define BHCR_ADDR_LINE (8'(`BHCR_IDX_LINE << 2))
`define BHCR_ADDR_PIN (8'(`BHCR_IDX_PIN << 2))
`define BHCR_ADDR_BRIDGE_CONTROL (8'(`BHCR_IDX_BRIDGE_CONTROL << 2))
`define BHCR_ADDR_EVT_STAT (8'(`BHCR_IDX_EVT_STAT << 2))
`define BHCR_ADDR_EVT_MASK (8'(`BHCR_IDX_EVT_MASK << 2))
`define BHCR_ADDR_ERR_CFG (8'(`BHCR_IDX_ERR_CFG << 2))
`define BHCR_BRIDGE_CONTROL_MASK 16'h005F
`define BHCR_BRIDGE_CONTROL_MASK_LO 8'h5F
`define BHCR_B_POISON 0
`define BHCR_B_ERRFWD 1
`define BHCR_B_ISA 2
`define BHCR_B_VGA 3
`define BHCR_B_VGA16 4
`define BHCR_B_SRST 6
`define BHCR_PIN_MAX 8'h04
`define BHCR_EV_POISON 0
`define BHCR_EV_ERRFWD 1
`define BHCR_EV_SRST 2
`define BHCR_EV_W 3
`define BHCR_ISA_LIMIT 32'h0001_0000
`define BHCR_ISA_TOP_LO 10'h100
`define BHCR_VGA_MEM_LO 32'h000A_0000
`define BHCR_VGA_MEM_HI 32'h000B_FFFF
`define BHCR_VGA_IO_A_LO 10'h3B0
`define BHCR_VGA_IO_A_HI 10'h3BB
`define BHCR_VGA_IO_B_LO 10'h3C0
`define BHCR_VGA_IO_B_HI 10'h3DF
`define BHCR_RESP_OK 2'h0
`define BHCR_RESP_ERR 2'h3
`endif

/* File: bhcr_pkg.sv */
package bhcr_pkg;
  typedef enum logic [1:0] {BHCR_IDLE = 2'h0, BHCR_RESP = 2'h1} bhcr_bus_t;
  typedef enum logic [2:0] {BHCR_NONE = 3'h0, BHCR_INTA = 3'h1, BHCR_INTB = 3'h2,
    BHCR_INTC = 3'h3, BHCR_INTD = 3'h4} bhcr_pin_t;
endpackage

/* File: bhcr_event_bit.sv */
`timescale 1ns/1ps
module bhcr_event_bit
  import bhcr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Event and clear
  input wire logic event_in,
  input wire logic clear_in,
  output logic flag_out
);
  logic flag;
  logic next_flag;
  // Set wins over a clear in the same cycle
  always_comb
  begin
    next_flag = (flag & ~clear_in) | event_in;
  end
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
      flag <= 1'b0;
    else
      flag <= next_flag;
  end
  assign flag_out = flag;
endmodule // bhcr_event_bit

/* File: bhcr_regs.sv */
`timescale 1ns/1ps
`include "bhcr_defines.svh"
module bhcr_regs
  import bhcr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Secondary side events
  input wire logic sec_poisoned_tlp_in,
  input wire logic sec_err_msg_in,
  // I/O and memory routing queries
  input wire logic io_in_range_in,
  input wire logic [31:0] io_addr_in,
  input wire logic [31:0] mem_addr_in,
  output logic io_route_down_out,
  output logic io_route_up_out,
  output logic vga_forward_out,
  // Error, reset and interrupt outputs
  output logic poison_report_out,
  output logic err_forward_out,
  output logic secondary_bus_reset_out,
  output logic [2:0] irq_pin_select_out,
  output logic irq_out
);
  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] irq_line_byte;
  logic [7:0] irq_pin_select;
  logic [15:0] bridge_control;
  logic [1:0] err_cfg;
  logic [`BHCR_EV_W-1:0] evt_mask;
  logic [7:0] next_irq_line_byte;
  logic [7:0] next_irq_pin_select;
  logic [15:0] next_bridge_control;
  logic [1:0] next_err_cfg;
  logic [`BHCR_EV_W-1:0] next_evt_mask;
  logic [`BHCR_EV_W-1:0] evt_stat;
  logic [`BHCR_EV_W-1:0] evt_set;
  logic [`BHCR_EV_W-1:0] evt_clr;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;
  logic srst_prev;
  // ****************************************
  // Bus slave
  // ****************************************
  bhcr_bus_t wr_st;
  bhcr_bus_t next_wr_st;
  bhcr_bus_t rd_st;
  bhcr_bus_t next_rd_st;
  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic [7:0] aw_addr;
  logic [7:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  logic do_write;
  assign s_axi_awready_out = (wr_st == BHCR_IDLE) && !aw_held;
  assign s_axi_wready_out = (wr_st == BHCR_IDLE) && !w_held;
  assign s_axi_arready_out = (rd_st == BHCR_IDLE);
  assign s_axi_bvalid_out = (wr_st == BHCR_RESP);
  assign s_axi_rvalid_out = (rd_st == BHCR_RESP);
  assign s_axi_bresp_out = bresp;
  assign s_axi_rresp_out = rresp;
  assign s_axi_rdata_out = rdata;
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_wr_st = wr_st;
    next_bresp = bresp;
    do_write = 1'b0;
    if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_in;
      next_w_strb = s_axi_wstrb_in;
    end
    unique case (wr_st)
      BHCR_IDLE:
      begin
        if (aw_held && w_held)
        begin
          do_write = 1'b1;
          next_bresp = wr_ok ? `BHCR_RESP_OK : `BHCR_RESP_ERR;
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_wr_st = BHCR_RESP;
        end
      end
      BHCR_RESP:
      begin
        if (s_axi_bready_in)
          next_wr_st = BHCR_IDLE;
      end
      default:
        next_wr_st = BHCR_IDLE;
    endcase
  end
  always_comb
  begin
    next_rd_st = rd_st;
    next_rdata = rdata;
    next_rresp = rresp;
    unique case (rd_st)
      BHCR_IDLE:
      begin
        if (s_axi_arvalid_in)
        begin
          next_rdata = rd_word;
          next_rresp = rd_ok ? `BHCR_RESP_OK : `BHCR_RESP_ERR;
          next_rd_st = BHCR_RESP;
        end
      end
      BHCR_RESP:
      begin
        if (s_axi_rready_in)
          next_rd_st = BHCR_IDLE;
      end
      default:
        next_rd_st = BHCR_IDLE;
    endcase
  end
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      wr_st <= BHCR_IDLE;
      rd_st <= BHCR_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bresp <= 2'h0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end
    else
    begin
      wr_st <= next_wr_st;
      rd_st <= next_rd_st;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bresp <= next_bresp;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end
  // ****************************************
  // Register decode
  // ****************************************
  always_comb
  begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    unique case ({s_axi_araddr_in[7:2], 2'b00})
      `BHCR_ADDR_ROM: rd_word = 32'h0000_0000;
      `BHCR_ADDR_LINE: rd_word = {24'h00_0000, irq_line_byte};
      `BHCR_ADDR_PIN: rd_word = {24'h00_0000, irq_pin_select};
      `BHCR_ADDR_BRIDGE_CONTROL: rd_word = {16'h0000, bridge_control & `BHCR_BRIDGE_CONTROL_MASK};
      `BHCR_ADDR_EVT_STAT: rd_word = {29'h0000_0000, evt_stat};
      `BHCR_ADDR_EVT_MASK: rd_word = {29'h0000_0000, evt_mask};
      `BHCR_ADDR_ERR_CFG: rd_word = {30'h0000_0000, err_cfg};
      default: rd_ok = 1'b0;
    endcase
  end
  always_comb
  begin
    wr_ok = 1'b1;
    next_irq_line_byte = irq_line_byte;
    next_irq_pin_select = irq_pin_select;
    next_bridge_control = bridge_control;
    next_evt_mask = evt_mask;
    next_err_cfg = err_cfg;
    evt_clr = '0;
    unique case ({aw_addr[7:2], 2'b00})
      `BHCR_ADDR_ROM: wr_ok = 1'b1;
      `BHCR_ADDR_LINE:
        if (do_write && w_strb[0])
          next_irq_line_byte = w_data[7:0];
      `BHCR_ADDR_PIN:
        if (do_write && w_strb[0])
          next_irq_pin_select = w_data[7:0];
      // Upper byte is all reserved, so it is never written and stays zero
      `BHCR_ADDR_BRIDGE_CONTROL:
        if (do_write && w_strb[0])
          next_bridge_control[7:0] = w_data[7:0] & `BHCR_BRIDGE_CONTROL_MASK_LO;
      `BHCR_ADDR_EVT_STAT:
        if (do_write && w_strb[0])
          evt_clr = w_data[`BHCR_EV_W-1:0];
      `BHCR_ADDR_EVT_MASK:
        if (do_write && w_strb[0])
          next_evt_mask = w_data[`BHCR_EV_W-1:0];
      `BHCR_ADDR_ERR_CFG:
        if (do_write && w_strb[0])
          next_err_cfg = w_data[1:0];
      default: wr_ok = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      irq_line_byte <= 8'h00;
      irq_pin_select <= 8'h00;
      bridge_control <= 16'h0000;
      evt_mask <= '0;
      err_cfg <= 2'h0;
      srst_prev <= 1'b0;
    end
    else
    begin
      irq_line_byte <= next_irq_line_byte;
      irq_pin_select <= next_irq_pin_select;
      bridge_control <= next_bridge_control;
      evt_mask <= next_evt_mask;
      err_cfg <= next_err_cfg;
      srst_prev <= bridge_control[`BHCR_B_SRST];
    end
  end
  // ****************************************
  // Bridge behaviour
  // ****************************************
  logic vga_io_hit;
  logic [9:0] io_low;
  logic io_upper_ok;
  assign io_low = io_addr_in[9:0];
  // Only low 10 bits compared unless wide decode is on
  assign io_upper_ok = !bridge_control[`BHCR_B_VGA16] || (io_addr_in[31:10] == 22'h00_0000);
  assign vga_io_hit = ((io_low >= `BHCR_VGA_IO_A_LO && io_low <= `BHCR_VGA_IO_A_HI) ||
    (io_low >= `BHCR_VGA_IO_B_LO && io_low <= `BHCR_VGA_IO_B_HI)) && io_upper_ok;
  logic isa_up;
  assign isa_up = bridge_control[`BHCR_B_ISA] && (io_addr_in < `BHCR_ISA_LIMIT) &&
    (io_low >= `BHCR_ISA_TOP_LO);
  assign io_route_up_out = io_in_range_in && isa_up;
  assign io_route_down_out = (io_in_range_in && !isa_up) ||
    (bridge_control[`BHCR_B_VGA] && vga_io_hit);
  assign vga_forward_out = bridge_control[`BHCR_B_VGA] &&
    ((mem_addr_in >= `BHCR_VGA_MEM_LO && mem_addr_in <= `BHCR_VGA_MEM_HI) || vga_io_hit);
  assign poison_report_out = sec_poisoned_tlp_in && bridge_control[`BHCR_B_POISON];
  assign err_forward_out = sec_err_msg_in && bridge_control[`BHCR_B_ERRFWD] && (|err_cfg);
  assign secondary_bus_reset_out = bridge_control[`BHCR_B_SRST];
  assign irq_pin_select_out = (irq_pin_select <= `BHCR_PIN_MAX) ? irq_pin_select[2:0] : BHCR_NONE;
  // ****************************************
  // Interrupts
  // ****************************************
  assign evt_set[`BHCR_EV_POISON] = poison_report_out;
  assign evt_set[`BHCR_EV_ERRFWD] = err_forward_out;
  assign evt_set[`BHCR_EV_SRST] = bridge_control[`BHCR_B_SRST] && !srst_prev;
  genvar gi;
  generate
    for (gi = 0; gi < `BHCR_EV_W; gi = gi + 1)
    begin : g_evt
      bhcr_event_bit u_bit (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .event_in(evt_set[gi]),
        .clear_in(evt_clr[gi]),
        .flag_out(evt_stat[gi])
      );
    end
  endgenerate
  assign irq_out = |(evt_stat & evt_mask);
  // ****************************************
  // Checks
  // ****************************************
  sequence s_srst_write;
    do_write && ({aw_addr[7:2], 2'b00} == `BHCR_ADDR_BRIDGE_CONTROL) && w_strb[0] && w_data[`BHCR_B_SRST];
  endsequence
  a_srst_follows_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_srst_write |=> secondary_bus_reset_out) else $error("reset not raised");
  a_srst_holds_set: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    secondary_bus_reset_out && !(do_write && ({aw_addr[7:2], 2'b00} == `BHCR_ADDR_BRIDGE_CONTROL))
    |=> secondary_bus_reset_out) else $error("reset dropped");
  a_rom_reads_zero: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (rd_st == BHCR_IDLE) && s_axi_arvalid_in && ({s_axi_araddr_in[7:2], 2'b00} == `BHCR_ADDR_ROM)
    |=> s_axi_rvalid_out && (s_axi_rdata_out == 32'h0000_0000)) else $error("rom not zero");
  a_line_stores: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    do_write && ({aw_addr[7:2], 2'b00} == `BHCR_ADDR_LINE) && w_strb[0]
    |=> irq_line_byte == w_data[7:0]) else $error("line not stored");
  a_pin_decode: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (irq_pin_select > `BHCR_PIN_MAX) |-> (irq_pin_select_out == BHCR_NONE)) else $error("pin bad");
  a_poison_gate: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    sec_poisoned_tlp_in && bridge_control[`BHCR_B_POISON] |=> evt_stat[`BHCR_EV_POISON])
    else $error("poison not reported");
  a_err_gate: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    sec_err_msg_in && bridge_control[`BHCR_B_ERRFWD] && (err_cfg != 2'h0) |-> err_forward_out)
    else $error("err not forwarded");
  a_isa_route: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    io_in_range_in && !bridge_control[`BHCR_B_ISA] |-> io_route_down_out && !io_route_up_out)
    else $error("io misrouted");
  a_vga_block: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !bridge_control[`BHCR_B_VGA] |-> !vga_forward_out) else $error("vga leak");
  a_reserved_zero: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $rose(s_axi_rvalid_out) && ($past(s_axi_araddr_in) == `BHCR_ADDR_BRIDGE_CONTROL) |->
    (s_axi_rdata_out[5] == 1'b0) && (s_axi_rdata_out[31:7] == 25'h0)) else $error("reserved set");
endmodule // bhcr_regs

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "bhcr_defines.svh"
module tb_top;
  import bhcr_pkg::*;
  // ****************************************
  // Signals and design
  // ****************************************
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, io_addr = 32'h0, mem_addr = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic poison = 1'b0, err_msg = 1'b0, in_range = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic up, down, vga, prep, efwd, srst, irq;
  logic [2:0] pin;
  int fails = 0;
  int total_checks = 0;
  bhcr_regs dut (.core_clk_in(clk), .rstn_in(rstn), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .sec_poisoned_tlp_in(poison), .sec_err_msg_in(err_msg),
    .io_in_range_in(in_range), .io_addr_in(io_addr), .mem_addr_in(mem_addr),
    .io_route_down_out(down), .io_route_up_out(up), .vga_forward_out(vga),
    .poison_report_out(prep), .err_forward_out(efwd), .secondary_bus_reset_out(srst),
    .irq_pin_select_out(pin), .irq_out(irq));
  // ****************************************
  // Helpers
  // ****************************************
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task automatic close_out;
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Handshakes are sampled at the falling edge, where every ready has settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] r;
    b_hs = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hs)
    begin
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      r = bresp;
      @(posedge clk);
      if (aw_hs)
        awvalid <= 1'b0;
      if (w_hs)
        wvalid <= 1'b0;
      if (b_hs)
        bready <= 1'b0;
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_hs, r_hs;
    logic [31:0] d;
    logic [1:0] r;
    r_hs = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hs)
    begin
      @(negedge clk);
      ar_hs = arvalid && arready;
      r_hs = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_hs)
        arvalid <= 1'b0;
      if (r_hs)
        rready <= 1'b0;
    end
    chk("rresp", {30'h0, er}, {30'h0, r});
    chk("rdata", ed, d);
  endtask
  task automatic route(input logic [4:0] ctl, input logic rng, input logic [31:0] io,
    input logic [31:0] mem, input logic eup, input logic edown, input logic evga);
    wr(`BHCR_ADDR_BRIDGE_CONTROL, {27'h0, ctl}, 4'h1, `BHCR_RESP_OK);
    in_range <= rng;
    io_addr <= io;
    mem_addr <= mem;
    @(negedge clk);
    chk("vga_forward", {31'h0, evga}, {31'h0, vga});
    if (rng)
    begin
      chk("route_up", {31'h0, eup}, {31'h0, up});
      chk("route_down", {31'h0, edown}, {31'h0, down});
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_rom;
    rd(`BHCR_ADDR_ROM, 32'h0, `BHCR_RESP_OK);
    rd(`BHCR_ADDR_LINE, 32'h0, `BHCR_RESP_OK);
    rd(`BHCR_ADDR_PIN, 32'h0, `BHCR_RESP_OK);
    rd(`BHCR_ADDR_BRIDGE_CONTROL, 32'h0, `BHCR_RESP_OK);
    rd(`BHCR_ADDR_EVT_STAT, 32'h0, `BHCR_RESP_OK);
    chk("pin_reset", 32'h0, {29'h0, pin});
    wr(`BHCR_ADDR_ROM, 32'hFFFF_FFFF, 4'hF, `BHCR_RESP_OK);
    rd(`BHCR_ADDR_ROM, 32'h0, `BHCR_RESP_OK);
    wr(8'h50, 32'h1, 4'hF, `BHCR_RESP_ERR);
    rd(8'h50, 32'h0, `BHCR_RESP_ERR);
  endtask
  task automatic t_line_pin;
    logic [7:0] v;
    wr(`BHCR_ADDR_LINE, 32'h0000_00A5, 4'h1, `BHCR_RESP_OK);
    // Codes above four are not for software use; the design drives no pin for them
    for (int i = 0; i < 6; i++)
    begin
      v = 8'(i);
      wr(`BHCR_ADDR_PIN, {24'h0, v}, 4'h1, `BHCR_RESP_OK);
      @(negedge clk);
      chk("pin_select", (i < 5) ? i : 0, {29'h0, pin});
    end
    rd(`BHCR_ADDR_LINE, 32'h0000_00A5, `BHCR_RESP_OK);
    rd(`BHCR_ADDR_PIN, 32'h0000_0005, `BHCR_RESP_OK);
    wr(`BHCR_ADDR_BRIDGE_CONTROL, 32'hFFFF_FFBF, 4'hF, `BHCR_RESP_OK);
    rd(`BHCR_ADDR_BRIDGE_CONTROL, 32'h0000_001F, `BHCR_RESP_OK);
  endtask
  task automatic t_errors;
    logic [2:0] c;
    wr(`BHCR_ADDR_BRIDGE_CONTROL, 32'h0, 4'h1, `BHCR_RESP_OK);
    poison <= 1'b1;
    @(negedge clk);
    chk("poison_off", 32'h0, {31'h0, prep});
    wr(`BHCR_ADDR_BRIDGE_CONTROL, 32'h0000_0001, 4'h1, `BHCR_RESP_OK);
    @(negedge clk);
    chk("poison_on", 32'h1, {31'h0, prep});
    @(posedge clk);
    poison <= 1'b0;
    err_msg <= 1'b1;
    // Table holds the forward bit, then both reporting enables
    for (int i = 0; i < 4; i++)
    begin
      c = (i == 3) ? 3'b011 : 3'(4 + i);
      wr(`BHCR_ADDR_BRIDGE_CONTROL, {30'h0, c[2], 1'b0}, 4'h1, `BHCR_RESP_OK);
      wr(`BHCR_ADDR_ERR_CFG, {30'h0, c[1:0]}, 4'h1, `BHCR_RESP_OK);
      @(negedge clk);
      chk("err_forward", {31'h0, c[2] & (|c[1:0])}, {31'h0, efwd});
    end
    @(posedge clk);
    err_msg <= 1'b0;
    rd(`BHCR_ADDR_EVT_STAT, 32'h3, `BHCR_RESP_OK);
  endtask
  task automatic t_irq_reset;
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`BHCR_ADDR_EVT_MASK, 32'h1, 4'h1, `BHCR_RESP_OK);
    @(negedge clk);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(`BHCR_ADDR_EVT_STAT, 32'h3, 4'h1, `BHCR_RESP_OK);
    rd(`BHCR_ADDR_EVT_STAT, 32'h0, `BHCR_RESP_OK);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    wr(`BHCR_ADDR_EVT_MASK, 32'h4, 4'h1, `BHCR_RESP_OK);
    wr(`BHCR_ADDR_BRIDGE_CONTROL, 32'h0000_0040, 4'h1, `BHCR_RESP_OK);
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("sec_reset_held", 32'h1, {31'h0, srst});
    chk("irq_reset_event", 32'h1, {31'h0, irq});
    wr(`BHCR_ADDR_BRIDGE_CONTROL, 32'h0, 4'h1, `BHCR_RESP_OK);
    @(negedge clk);
    chk("sec_reset_free", 32'h0, {31'h0, srst});
    wr(`BHCR_ADDR_EVT_STAT, 32'h4, 4'h1, `BHCR_RESP_OK);
    @(negedge clk);
    chk("irq_off", 32'h0, {31'h0, irq});
  endtask
  task automatic t_routes;
    route(5'h00, 1'b1, 32'h0000_0300, 32'h0, 1'b0, 1'b1, 1'b0);
    route(5'h04, 1'b1, 32'h0000_0300, 32'h0, 1'b1, 1'b0, 1'b0);
    route(5'h04, 1'b1, 32'h0000_FFFF, 32'h0, 1'b1, 1'b0, 1'b0);
    route(5'h04, 1'b1, 32'h0000_00FF, 32'h0, 1'b0, 1'b1, 1'b0);
    route(5'h04, 1'b1, 32'h0001_0300, 32'h0, 1'b0, 1'b1, 1'b0);
    route(5'h08, 1'b0, 32'h0, 32'h000A_0000, 1'b0, 1'b0, 1'b1);
    route(5'h00, 1'b0, 32'h0, 32'h000B_FFFF, 1'b0, 1'b0, 1'b0);
    route(5'h08, 1'b0, 32'h0000_07C0, 32'h0, 1'b0, 1'b0, 1'b1);
    route(5'h18, 1'b0, 32'h0000_07C0, 32'h0, 1'b0, 1'b0, 1'b0);
    route(5'h18, 1'b0, 32'h0000_03C0, 32'h0, 1'b0, 1'b0, 1'b1);
    route(5'h10, 1'b0, 32'h0000_03C0, 32'h0, 1'b0, 1'b0, 1'b0);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_reset_rom();
    t_line_pin();
    t_errors();
    t_irq_reset();
    t_routes();
    close_out();
  end
  initial
  begin
    repeat (4000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule // tb_top
